/* File: src/rcw_pkg.sv */
// Package of constants and types for the rotary coordinate wrap positioning block
package rcw_pkg;
  // ==========================================================================
  // Register byte offsets (Wishbone, one 32-bit word each)
  localparam logic [7:0] RCW_OFS_CTRL = 8'h00;
  localparam logic [7:0] RCW_OFS_START = 8'h04;
  localparam logic [7:0] RCW_OFS_END = 8'h08;
  localparam logic [7:0] RCW_OFS_EXT_DIST = 8'h0c;
  localparam logic [7:0] RCW_OFS_HOME_DIST = 8'h10;
  localparam logic [7:0] RCW_OFS_MON_SEL = 8'h14;
  localparam logic [7:0] RCW_OFS_STATUS = 8'h18;
  localparam logic [7:0] RCW_OFS_TARGET = 8'h1c;
  localparam logic [7:0] RCW_OFS_MON1 = 8'h20;
  localparam logic [7:0] RCW_OFS_MON2 = 8'h24;
  localparam logic [7:0] RCW_OFS_CMON1 = 8'h28;
  localparam logic [7:0] RCW_OFS_CMON2 = 8'h2c;
  localparam logic [7:0] RCW_OFS_OMON1 = 8'h30;
  localparam logic [7:0] RCW_OFS_OMON2 = 8'h34;
  localparam logic [7:0] RCW_OFS_PANEL_CMD = 8'h38;
  localparam logic [7:0] RCW_OFS_PANEL_FB = 8'h3c;
  // ==========================================================================
  // Control field positions and reset values
  localparam int RCW_CTRL_METHOD_LSB = 0;
  localparam int RCW_CTRL_METHOD_W = 4;
  localparam int RCW_CTRL_ENABLE_BIT = 4;
  localparam logic [31:0] RCW_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] RCW_START_RST = 32'h0000_0000;
  localparam logic [31:0] RCW_END_RST = 32'h0000_0000;
  localparam logic [31:0] RCW_DIST_RST = 32'h0000_0000;
  localparam logic [31:0] RCW_MON_SEL_RST = 32'h0000_0000;
  // Maximum span corrections per wrap; one is enough when |distance| < span
  localparam int RCW_WRAP_STEPS = 8;
  // ==========================================================================
  // Move method codes of the modular move method switch
  localparam logic [3:0] RCW_METHOD_ABS = 4'h0;
  localparam logic [3:0] RCW_METHOD_SHORT = 4'h3;
  // Monitor slot select codes
  localparam logic [7:0] RCW_SLOT_FB = 8'h00;
  localparam logic [7:0] RCW_SLOT_CMD = 8'h01;
  localparam logic [7:0] RCW_SLOT_LAT1 = 8'h03;
  localparam logic [7:0] RCW_SLOT_LAT2 = 8'h04;
  localparam logic [7:0] RCW_SLOT_LOOP = 8'h09;
  // Common monitor codes
  localparam logic [7:0] RCW_CMON_TARGET = 8'h00;
  localparam logic [7:0] RCW_CMON_PREF = 8'h01;
  localparam logic [7:0] RCW_CMON_OFFSET = 8'h02;
  // Option monitor codes
  localparam logic [7:0] RCW_OMON_PREV1 = 8'h80;
  localparam logic [7:0] RCW_OMON_PREV2 = 8'h81;
  // ==========================================================================
  // Latch sequencer states
  typedef enum logic [1:0] {
    RCW_IDLE = 2'b00,
    RCW_WRAP = 2'b01,
    RCW_DONE = 2'b10
  } rcw_state_t;
endpackage : rcw_pkg

/* File: src/rcw_wrap.sv */
// Modular wrap unit: folds a signed position into the start..end range
`timescale 1ns/1ps
module rcw_wrap
  import rcw_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic en_i,
  input wire logic [WIDTH-1:0] pos_i,
  input wire logic [WIDTH-1:0] start_i,
  input wire logic [WIDTH-1:0] end_i,
  output logic [WIDTH-1:0] pos_o
);
  // ==========================================================================
  // Combinational fold, then one output register
  logic signed [WIDTH+1:0] span;
  logic signed [WIDTH+1:0] steps [0:RCW_WRAP_STEPS];
  logic [WIDTH-1:0] pos_r;

  if (WIDTH < 2 || WIDTH > 64) begin : g_bad_width
    $error("rcw_wrap: WIDTH out of range");
  end

  assign span = $signed({{2{end_i[WIDTH-1]}}, end_i}) - $signed({{2{start_i[WIDTH-1]}}, start_i}) + 1;
  assign steps[0] = $signed({{2{pos_i[WIDTH-1]}}, pos_i});

  // Repeated span correction; bounded so the fold stays one cycle deep
  genvar g;
  generate
    for (g = 0; g < RCW_WRAP_STEPS; g++) begin : g_fold
      always_comb begin
        if (steps[g] > $signed({{2{end_i[WIDTH-1]}}, end_i})) begin
          steps[g+1] = steps[g] - span;
        end else if (steps[g] < $signed({{2{start_i[WIDTH-1]}}, start_i})) begin
          steps[g+1] = steps[g] + span;
        end else begin
          steps[g+1] = steps[g];
        end
      end
    end
  endgenerate

  // Disabled modular system passes the position through unchanged
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pos_r <= '0;
    end else if (en_i && span > 0) begin
      pos_r <= steps[RCW_WRAP_STEPS][WIDTH-1:0];
    end else begin
      pos_r <= pos_i;
    end
  end

  assign pos_o = pos_r;
endmodule : rcw_wrap

/* File: src/rcw_core.sv */
// Rotary coordinate wrap positioning core with Wishbone register slave
`timescale 1ns/1ps
module rcw_core
  import rcw_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command strobes from the fieldbus decoder
  input wire logic positioning_command_i,
  input wire logic external_trigger_positioning_command_i,
  input wire logic external_trigger_constant_speed_command_i,
  input wire logic homing_command_i,
  input wire logic speed_control_command_i,
  input wire logic torque_control_command_i,
  input wire logic [WIDTH-1:0] command_target_i,
  // Latch signal and motion state from the drive
  input wire logic latch_event_i,
  input wire logic latch_sel_i,
  input wire logic [WIDTH-1:0] feedback_position_i,
  input wire logic [WIDTH-1:0] filtered_command_position_i,
  input wire logic [WIDTH-1:0] prefilter_reference_position_i,
  input wire logic [WIDTH-1:0] position_deviation_i,
  input wire logic [WIDTH-1:0] coordinate_offset_value_i,
  // Positioning outputs
  output logic [WIDTH-1:0] final_target_o,
  output logic move_dir_neg_o,
  output logic move_start_o,
  output logic [3:0] move_method_o,
  output logic timing_dependent_o,
  output logic [WIDTH-1:0] panel_command_position_o,
  output logic [WIDTH-1:0] panel_feedback_position_o
);
  // ==========================================================================
  // Declarations
  logic [31:0] ctrl_r;
  logic [31:0] start_r;
  logic [31:0] end_r;
  logic [31:0] ext_dist_r;
  logic [31:0] home_dist_r;
  logic [31:0] mon_sel_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_nxt;
  logic wb_req;
  logic velocity_mode_r;
  logic [3:0] method_r;
  logic timing_dep_r;
  logic homing_r;
  logic armed_r;
  logic [WIDTH-1:0] lat1_r;
  logic [WIDTH-1:0] lat2_r;
  logic [WIDTH-1:0] lat1_prev_r;
  logic [WIDTH-1:0] lat2_prev_r;
  logic [WIDTH-1:0] target_r;
  logic [WIDTH-1:0] sum_r;
  logic dir_neg_r;
  logic start_pulse_r;
  logic [WIDTH-1:0] loop_pos;
  logic [WIDTH-1:0] w_tgt;
  logic [WIDTH-1:0] w_fb;
  logic [WIDTH-1:0] w_cmd;
  logic [WIDTH-1:0] w_loop;
  logic [WIDTH-1:0] w_pref;
  logic [WIDTH-1:0] w_l1;
  logic [WIDTH-1:0] w_l2;
  logic [WIDTH-1:0] w_p1;
  logic [WIDTH-1:0] w_p2;
  logic [WIDTH-1:0] final_w;
  logic modular_en;
  rcw_state_t state_r;

  if (WIDTH != 32) begin : g_bad_width
    $error("rcw_core: WIDTH must be 32 to fit the register map");
  end
  // Byte-lane merge used by every writable register
  function automatic logic [31:0] rcw_merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) res[i*8 +: 8] = dat[i*8 +: 8];
    end
    return res;
  endfunction : rcw_merge

  // Monitor code decode, shared by both slots of each monitor group
  function automatic logic [31:0] rcw_slot(input logic [7:0] code, input logic [31:0] fb, input logic [31:0] cmd,
                                           input logic [31:0] l1, input logic [31:0] l2, input logic [31:0] lp);
    case (code)
      RCW_SLOT_FB: return fb;
      RCW_SLOT_CMD: return cmd;
      RCW_SLOT_LAT1: return l1;
      RCW_SLOT_LAT2: return l2;
      RCW_SLOT_LOOP: return lp;
      default: return 32'h0000_0000;
    endcase
  endfunction : rcw_slot
  function automatic logic [31:0] rcw_cmon(input logic [7:0] code, input logic [31:0] tg, input logic [31:0] pr,
                                           input logic [31:0] ofs, input logic [31:0] p1, input logic [31:0] p2);
    case (code)
      RCW_CMON_TARGET: return tg;
      RCW_CMON_PREF: return pr;
      RCW_CMON_OFFSET: return ofs;
      RCW_OMON_PREV1: return p1;
      RCW_OMON_PREV2: return p2;
      default: return 32'h0000_0000;
    endcase
  endfunction : rcw_cmon

  assign modular_en = ctrl_r[RCW_CTRL_ENABLE_BIT];
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  assign loop_pos = feedback_position_i + position_deviation_i;

  // ==========================================================================
  // Wrap units: every monitored position except the coordinate offset passes through one register stage
  rcw_wrap #(.WIDTH(WIDTH)) u_w_tgt (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en), .pos_i(target_r),
    .start_i(start_r), .end_i(end_r), .pos_o(w_tgt));
  rcw_wrap #(.WIDTH(WIDTH)) u_w_fb (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en),
    .pos_i(feedback_position_i), .start_i(start_r), .end_i(end_r), .pos_o(w_fb));
  rcw_wrap #(.WIDTH(WIDTH)) u_w_cmd (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en),
    .pos_i(filtered_command_position_i), .start_i(start_r), .end_i(end_r), .pos_o(w_cmd));
  rcw_wrap #(.WIDTH(WIDTH)) u_w_loop (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en), .pos_i(loop_pos),
    .start_i(start_r), .end_i(end_r), .pos_o(w_loop));
  rcw_wrap #(.WIDTH(WIDTH)) u_w_pref (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en),
    .pos_i(prefilter_reference_position_i), .start_i(start_r), .end_i(end_r), .pos_o(w_pref));
  rcw_wrap #(.WIDTH(WIDTH)) u_w_l1 (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en), .pos_i(lat1_r),
    .start_i(start_r), .end_i(end_r), .pos_o(w_l1));
  rcw_wrap #(.WIDTH(WIDTH)) u_w_l2 (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en), .pos_i(lat2_r),
    .start_i(start_r), .end_i(end_r), .pos_o(w_l2));
  rcw_wrap #(.WIDTH(WIDTH)) u_w_p1 (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en), .pos_i(lat1_prev_r),
    .start_i(start_r), .end_i(end_r), .pos_o(w_p1));
  rcw_wrap #(.WIDTH(WIDTH)) u_w_p2 (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en), .pos_i(lat2_prev_r),
    .start_i(start_r), .end_i(end_r), .pos_o(w_p2));
  // Final target fold: latch plus final distance, wrapped
  rcw_wrap #(.WIDTH(WIDTH)) u_w_fin (.clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(modular_en), .pos_i(sum_r),
    .start_i(start_r), .end_i(end_r), .pos_o(final_w));

  // ==========================================================================
  // Wishbone write side; writes take effect on the acknowledging edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= RCW_CTRL_RST;
      start_r <= RCW_START_RST;
      end_r <= RCW_END_RST;
      ext_dist_r <= RCW_DIST_RST;
      home_dist_r <= RCW_DIST_RST;
      mon_sel_r <= RCW_MON_SEL_RST;
    end else if (ack_r && wb_cyc_i && wb_stb_i && wb_we_i) begin
      case (wb_adr_i)
        RCW_OFS_CTRL: ctrl_r <= rcw_merge(ctrl_r, wb_dat_i, wb_sel_i);
        RCW_OFS_START: start_r <= rcw_merge(start_r, wb_dat_i, wb_sel_i);
        RCW_OFS_END: end_r <= rcw_merge(end_r, wb_dat_i, wb_sel_i);
        RCW_OFS_EXT_DIST: ext_dist_r <= rcw_merge(ext_dist_r, wb_dat_i, wb_sel_i);
        RCW_OFS_HOME_DIST: home_dist_r <= rcw_merge(home_dist_r, wb_dat_i, wb_sel_i);
        RCW_OFS_MON_SEL: mon_sel_r <= rcw_merge(mon_sel_r, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero and still acknowledge
  always_comb begin
    case (wb_adr_i)
      RCW_OFS_CTRL: rd_nxt = ctrl_r;
      RCW_OFS_START: rd_nxt = start_r;
      RCW_OFS_END: rd_nxt = end_r;
      RCW_OFS_EXT_DIST: rd_nxt = ext_dist_r;
      RCW_OFS_HOME_DIST: rd_nxt = home_dist_r;
      RCW_OFS_MON_SEL: rd_nxt = mon_sel_r;
      RCW_OFS_STATUS: rd_nxt = {24'h00_0000, 1'b0, timing_dep_r, dir_neg_r, state_r == RCW_WRAP,
                                velocity_mode_r, armed_r, homing_r, 1'b0};
      RCW_OFS_TARGET: rd_nxt = w_tgt;
      RCW_OFS_MON1: rd_nxt = rcw_slot(mon_sel_r[7:0], w_fb, w_cmd, w_l1, w_l2, w_loop);
      RCW_OFS_MON2: rd_nxt = rcw_slot(mon_sel_r[15:8], w_fb, w_cmd, w_l1, w_l2, w_loop);
      RCW_OFS_CMON1: rd_nxt = rcw_cmon(mon_sel_r[23:16], w_tgt, w_pref, coordinate_offset_value_i, w_p1, w_p2);
      RCW_OFS_CMON2: rd_nxt = rcw_cmon(mon_sel_r[31:24], w_tgt, w_pref, coordinate_offset_value_i, w_p1, w_p2);
      RCW_OFS_PANEL_CMD: rd_nxt = w_cmd;
      RCW_OFS_PANEL_FB: rd_nxt = w_fb;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // Single-wait ack: one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      if (wb_req && !wb_we_i) dat_r <= rd_nxt;
    end
  end
  assign wb_ack_o = ack_r && wb_cyc_i && wb_stb_i;
  assign wb_dat_o = dat_r;

  // ==========================================================================
  // Control mode tracking and move method choice
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      velocity_mode_r <= 1'b0;
      method_r <= 4'h0;
      timing_dep_r <= 1'b0;
    end else begin
      if (speed_control_command_i || torque_control_command_i || external_trigger_constant_speed_command_i) begin
        velocity_mode_r <= 1'b1;
      end else if (positioning_command_i || external_trigger_positioning_command_i || homing_command_i) begin
        velocity_mode_r <= 1'b0;
      end
      if ((positioning_command_i || external_trigger_positioning_command_i) && velocity_mode_r) begin
        method_r <= ctrl_r[RCW_CTRL_METHOD_LSB +: RCW_CTRL_METHOD_W];
        // Path then hinges on where the axis sits at the switch instant
        timing_dep_r <= (ctrl_r[RCW_CTRL_METHOD_LSB +: RCW_CTRL_METHOD_W] == RCW_METHOD_ABS) ||
                        (ctrl_r[RCW_CTRL_METHOD_LSB +: RCW_CTRL_METHOD_W] == RCW_METHOD_SHORT);
      end
    end
  end

  // ==========================================================================
  // Latch sequencer: arm on command, latch, add distance, wrap, start move
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= RCW_IDLE;
      armed_r <= 1'b0;
      homing_r <= 1'b0;
      sum_r <= '0;
      dir_neg_r <= 1'b0;
      start_pulse_r <= 1'b0;
      target_r <= '0;
    end else begin
      start_pulse_r <= 1'b0;
      if (positioning_command_i) begin
        target_r <= command_target_i; // Host keeps this in range
      end
      case (state_r)
        RCW_IDLE: begin
          if (modular_en && (external_trigger_constant_speed_command_i || external_trigger_positioning_command_i)) begin
            armed_r <= 1'b1;
            homing_r <= 1'b0;
          end else if (modular_en && homing_command_i) begin
            armed_r <= 1'b1;
            homing_r <= 1'b1;
          end else if (armed_r && latch_event_i) begin
            armed_r <= 1'b0;
            sum_r <= feedback_position_i + (homing_r ? home_dist_r : ext_dist_r);
            dir_neg_r <= homing_r ? home_dist_r[31] : ext_dist_r[31];
            state_r <= RCW_WRAP;
          end
        end
        RCW_WRAP: state_r <= RCW_DONE; // Wrap unit registers its result here
        RCW_DONE: begin
          target_r <= final_w;
          start_pulse_r <= 1'b1;
          state_r <= RCW_IDLE;
        end
        default: state_r <= RCW_IDLE;
      endcase
    end
  end

  // Latched position history, previous value kept for option monitors
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lat1_r <= '0;
      lat2_r <= '0;
      lat1_prev_r <= '0;
      lat2_prev_r <= '0;
    end else if (latch_event_i) begin
      if (!latch_sel_i) begin
        lat1_prev_r <= lat1_r;
        lat1_r <= feedback_position_i;
      end else begin
        lat2_prev_r <= lat2_r;
        lat2_r <= feedback_position_i;
      end
    end
  end

  assign final_target_o = target_r;
  assign move_dir_neg_o = dir_neg_r;
  assign move_start_o = start_pulse_r;
  assign move_method_o = method_r;
  assign timing_dependent_o = timing_dep_r;
  assign panel_command_position_o = w_cmd;
  assign panel_feedback_position_o = w_fb;

  // ==========================================================================
  // Checks
  sequence s_latch_taken;
    state_r == RCW_IDLE && armed_r && latch_event_i && !homing_command_i &&
      !external_trigger_constant_speed_command_i && !external_trigger_positioning_command_i;
  endsequence
  chk_start_after_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_latch_taken |-> ##3 start_pulse_r) else $error("move start missing after latch");
  chk_dir_sign_pos: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_latch_taken and (!homing_r && !ext_dist_r[31]) |=> !dir_neg_r) else $error("positive distance gave negative move");
  chk_dir_sign_neg: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_latch_taken and (!homing_r && ext_dist_r[31]) |=> dir_neg_r) else $error("negative distance gave positive move");
  chk_home_dir: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_latch_taken and homing_r |=> dir_neg_r == $past(home_dist_r[31])) else $error("homing direction wrong");
  chk_target_in_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    start_pulse_r && modular_en && $signed(end_r) >= $signed(start_r) |->
      $signed(target_r) >= $signed(start_r) && $signed(target_r) <= $signed(end_r))
    else $error("final target outside modular range");
  chk_method_take: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    positioning_command_i && velocity_mode_r |=> method_r == $past(ctrl_r[3:0])) else $error("move method not taken");
  chk_timing_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    positioning_command_i && velocity_mode_r && ctrl_r[3:0] == 4'h3 |=> timing_dep_r)
    else $error("shortest path not flagged timing dependent");
  chk_prev_latch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    latch_event_i && !latch_sel_i |=> lat1_prev_r == $past(lat1_r)) else $error("previous latch one lost");
  chk_ack_drop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ack_r |=> !ack_r) else $error("ack held two cycles");
endmodule : rcw_core

/* File: testbench/rcw_host.sv */
// Host controller model: command strobes, positioning target and latch signal
`timescale 1ns/1ps
module rcw_host (
  input wire logic clk_i,
  output logic [5:0] cmd_o,
  output logic [31:0] target_o,
  output logic latch_o
);
  // ==========================================================================
  // Idle levels until the bench asks for traffic
  initial begin
    cmd_o = '0;
    target_o = '0;
    latch_o = 1'b0;
  end
  // One-cycle command strobe; targets are kept inside start..end
  task send(input logic [5:0] c, input logic [31:0] t);
    @(posedge clk_i);
    cmd_o <= c;
    target_o <= t;
    @(posedge clk_i);
    cmd_o <= '0;
  endtask : send
  // One-cycle latch signal
  task latch();
    @(posedge clk_i);
    latch_o <= 1'b1;
    @(posedge clk_i);
    latch_o <= 1'b0;
  endtask : latch
endmodule : rcw_host

/* File: testbench/tb.sv */
// Self-checking bench for the rotary coordinate wrap core
`timescale 1ns/1ps
module tb;
  import rcw_pkg::*;
  localparam int ST = 0;
  localparam int EN = 3599;
  logic clk_i = 0, rst_b_i = 0, cyc = 0, we = 0, ack, mst, dn, td;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, rdat, fb = '0, dev = '0, ofs = '0, fcp = '0, pre = '0, ft, pc, pf, tg;
  logic [5:0] cmd;
  logic lat_s, lsel = 0;
  logic [3:0] mm;
  logic [31:0] rd_q[$];
  logic [32:0] mv_q[$];
  int errors = 0, n_checks = 0, seed = 12, last1 = 0, prev1 = 0, lv;
  int dl[6] = '{500, 3000, 5000, -500, -3000, -5000};
  rcw_core rcw_core_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .positioning_command_i(cmd[0]), .external_trigger_positioning_command_i(cmd[1]),
    .external_trigger_constant_speed_command_i(cmd[2]), .homing_command_i(cmd[3]),
    .speed_control_command_i(cmd[4]), .torque_control_command_i(cmd[5]), .command_target_i(tg),
    .latch_event_i(lat_s), .latch_sel_i(lsel), .feedback_position_i(fb), .filtered_command_position_i(fcp),
    .prefilter_reference_position_i(pre), .position_deviation_i(dev), .coordinate_offset_value_i(ofs),
    .final_target_o(ft), .move_dir_neg_o(dn), .move_start_o(mst), .move_method_o(mm), .timing_dependent_o(td),
    .panel_command_position_o(pc), .panel_feedback_position_o(pf));
  rcw_host rcw_host_i (.clk_i(clk_i), .cmd_o(cmd), .target_o(tg), .latch_o(lat_s));
  // ==========================================================================
  // Helpers
  initial forever #5 clk_i = ~clk_i;
  // Reference fold; repeats the span step so far-out sums still land inside
  function automatic int wrapv(int p);
    while (p > EN) p -= EN - ST + 1;
    while (p < ST) p += EN - ST + 1;
    return p;
  endfunction : wrapv
  task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task close_out();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // Classic cycle: hold everything until ack is sampled, then idle a cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd
  // ==========================================================================
  // Watcher: oldest note against each result as it appears
  always @(posedge clk_i) begin
    if (ack === 1'b1 && cyc && !we && rd_q.size() > 0) chk("read", rdat, rd_q.pop_front());
    if (mst === 1'b1 && mv_q.size() > 0) chk("move", {dn, ft}, mv_q.pop_front());
  end
  // Watchdog well past the fewer than two hundred cycles the run needs
  initial begin
    #200000;
    errors++;
    close_out();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    rd(RCW_OFS_CTRL, RCW_CTRL_RST);
    wb(1'b1, RCW_OFS_START, ST);
    wb(1'b1, RCW_OFS_END, EN);
    wb(1'b1, RCW_OFS_CTRL, 32'h0000_0010);
    // Latch sequences: ext positioning, ext feed, homing, both signs
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, (i % 3 == 2) ? RCW_OFS_HOME_DIST : RCW_OFS_EXT_DIST, dl[i]);
      rcw_host_i.send(6'h02 << (i % 3), 32'h0000_0000);
      lv = {$random(seed)} % 3600;
      repeat (2) @(posedge clk_i);
      fb <= lv;
      prev1 = last1;
      last1 = lv;
      mv_q.push_back({dl[i] < 0, 32'(wrapv(lv + dl[i]))});
      rcw_host_i.latch();
      repeat (4) @(posedge clk_i);
    end
    chk("moves left", mv_q.size(), 0);
    // Switch from speed or torque control to positioning per method
    foreach (dl[i]) if (i < 3) begin
      wb(1'b1, RCW_OFS_CTRL, 32'h0000_0010 | (i == 1 ? 3 : i * 1));
      rcw_host_i.send(i == 1 ? 6'h20 : 6'h10, 32'h0000_0000);
      rcw_host_i.send(6'h01, 32'd1800);
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      chk("method", mm, (i == 1) ? 4'h3 : 4'(i));
      chk("timing", td, i != 2);
      @(posedge clk_i);
    end
    // Monitors: loop input, feedback, previous latch one, offset, panel
    fb <= 32'd3700;
    dev <= -32'sd200;
    ofs <= 32'd5;
    fcp <= -32'sd100;
    wb(1'b1, RCW_OFS_MON_SEL, 32'h0280_0009);
    rd(RCW_OFS_MON1, 32'd3500);
    rd(RCW_OFS_MON2, 32'd100);
    rd(RCW_OFS_CMON1, prev1);
    rd(RCW_OFS_CMON2, 32'd5);
    rd(8'h40, 32'h0000_0000);
    rd(RCW_OFS_END, EN);
    @(negedge clk_i);
    chk("panel fb", pf, 32'd100);
    chk("panel cmd", pc, 32'd3500);
    // Latch two history, command slot, prefilter, target and latch one codes
    lsel <= 1'b1;
    pre <= 32'd3601;
    rcw_host_i.latch();
    fb <= 32'd10;
    rcw_host_i.latch();
    wb(1'b1, RCW_OFS_MON_SEL, 32'h0181_0104);
    rd(RCW_OFS_MON1, 32'd10);
    rd(RCW_OFS_MON2, 32'd3500);
    rd(RCW_OFS_CMON1, 32'd100);
    rd(RCW_OFS_CMON2, 32'd1);
    wb(1'b1, RCW_OFS_MON_SEL, 32'h0000_0003);
    rd(RCW_OFS_MON1, last1);
    rd(RCW_OFS_CMON1, 32'd1800);
    close_out();
  end
endmodule : tb
